// File: hw/pac_pkg.sv
package pac_pkg;
  // Register word indices matched against paddr[5:2] (byte offsets are four times these).
  localparam logic [3:0] REG_IDX_CTRL = 4'h0;
  localparam logic [3:0] REG_IDX_STAT = 4'h1;
  localparam logic [3:0] REG_IDX_ADV = 4'h4;
  localparam logic [3:0] REG_IDX_PART = 4'h5;
  localparam logic [3:0] REG_IDX_CFG = 4'h8;
  localparam logic [3:0] REG_IDX_PORTSEL = 4'h9;
  // Control register fields.
  localparam int CTRL_RESTART = 9;
  localparam int CTRL_DUPLEX = 8;
  localparam int CTRL_ANEN = 12;
  localparam int CTRL_SPEED = 13;
  // Status register fields.
  localparam logic [15:0] STAT_FIXED = 16'hF809;
  localparam int STAT_ANDONE = 5;
  localparam int STAT_RFAULT = 4;
  localparam int STAT_LINK = 2;
  // Advertisement fields.
  localparam int ADV_10H = 5;
  localparam int ADV_10F = 6;
  localparam int ADV_100H = 7;
  localparam int ADV_100F = 8;
  localparam int ADV_RFAULT = 13;
  localparam logic [15:0] ADV_SELECTOR = 16'h0001;
  // Configuration register fields.
  localparam int CFG_INTPOL = 15;
  localparam int CFG_ADVALL = 0;
  localparam int CFG_ADVSINGLE = 1;
  localparam int CFG_IEEE = 2;
  localparam logic [15:0] CFG_RESET = 16'h0001;
  // Resolved modes.
  localparam logic [1:0] MODE_100F = 2'h3;
  localparam logic [1:0] MODE_100H = 2'h2;
  localparam logic [1:0] MODE_10F = 2'h1;
  localparam logic [1:0] MODE_10H = 2'h0;
  // Negotiation timing.
  localparam int CLK_HZ = 10000000;
  localparam int NEG_TIME_US = 100;
  localparam int NEG_CYCLES = NEG_TIME_US * (CLK_HZ / 1000000);
endpackage

// File: hw/pac_autoneg.sv
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module pac_autoneg (
  // Clock, enable and reset.
  input wire logic clock,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic power_on_rc_input,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Straps.
  input wire logic [1:0] portNegDisable,
  input wire logic [1:0] portHalfDuplexHint,
  input wire logic [1:0] portLowSpeedHint,
  input wire logic [1:0] portFlowCtlOff,
  input wire logic auto_crossover_enable,
  input wire logic port0_crossover_select,
  // Serial configuration pins.
  input wire logic romSelectIn,
  output logic romSelectOut,
  output logic romSelectOe,
  input wire logic serialClockIn,
  output logic serialClockOut,
  output logic serialClockOe,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe,
  input wire logic rom_serial_in,
  // Serial engine side.
  input wire logic engClock,
  input wire logic engData,
  input wire logic engDataOe,
  input wire logic engSelect,
  output logic engDataIn,
  output logic serialPathSelect,
  // Link partner exchange.
  input wire logic partnerValid,
  input wire logic [15:0] partnerWord,
  input wire logic linkUp,
  output logic [15:0] link_pulse_burst,
  output logic burstValid,
  // Resolved state and interrupt.
  output logic [1:0] resolvedMode,
  output logic [1:0] flowCtlEnable,
  output logic crossoverMdi,
  input wire logic intEvent,
  output logic intOut,
  output logic intOe
);
  import pac_pkg::*;

  typedef enum logic [3:0] {
    PAC_IDLE = 4'h1,
    PAC_SEND = 4'h2,
    PAC_DONE = 4'h4,
    PAC_FORCE = 4'h8
  } pac_state_t;

  // Mode of a 4-bit ability set: 100F,100H,10F,10H.
  function automatic logic [1:0] bestMode(input logic [3:0] ab);
    if (ab[3]) bestMode = MODE_100F;
    else if (ab[2]) bestMode = MODE_100H;
    else if (ab[1]) bestMode = MODE_10F;
    else bestMode = MODE_10H;
  endfunction

  function automatic logic [3:0] abil(input logic [15:0] w);
    abil = {w[ADV_100F], w[ADV_100H], w[ADV_10F], w[ADV_10H]};
  endfunction

  // Reset and pin synchronisers.
  logic rcMeta_r, rcSync_r, rcSeen_r;
  logic [9:0] pinMeta_r, pinSync_r;
  logic [2:0] serMeta_r, serSync_r;
  logic [1:0] partMeta_r, partSync_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rcMeta_r <= 1'b0;
      rcSync_r <= 1'b0;
      pinMeta_r <= 10'h000;
      pinSync_r <= 10'h000;
      serMeta_r <= 3'h0;
      serSync_r <= 3'h0;
      partMeta_r <= 2'h0;
      partSync_r <= 2'h0;
    end else if (clkEn) begin
      rcMeta_r <= power_on_rc_input;
      rcSync_r <= rcMeta_r;
      pinMeta_r <= {portNegDisable, portHalfDuplexHint, portLowSpeedHint, portFlowCtlOff,
                    auto_crossover_enable, port0_crossover_select};
      pinSync_r <= pinMeta_r;
      serMeta_r <= {romSelectIn, serialDataIn, rom_serial_in};
      serSync_r <= serMeta_r;
      partMeta_r <= {partnerValid, linkUp};
      partSync_r <= partMeta_r;
    end
  end

  // Strap capture one cycle after internal reset rises.
  logic [10:0] strap_r, strap_nxt;
  logic capture;
  assign capture = rcSync_r && !rcSeen_r;
  always_comb begin
    strap_nxt = strap_r;
    if (capture) begin
      strap_nxt = {serSync_r[2], pinSync_r};
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strap_r <= 11'h000;
      rcSeen_r <= 1'b0;
    end else if (clkEn) begin
      strap_r <= strap_nxt;
      rcSeen_r <= rcSync_r;
    end
  end
  // Port 0 strap fields.
  logic negDis, halfHint, lowHint, xoEn, xoSel;
  assign negDis = strap_r[8];
  assign halfHint = strap_r[6];
  assign lowHint = strap_r[4];
  assign xoEn = strap_r[1];
  assign xoSel = strap_r[0];

  // Pin-derived advertisement per the speed table.
  function automatic logic [3:0] pinAbil(input logic [15:0] c, input logic lo,
                                         input logic hf);
    logic [3:0] a;
    a = 4'hF;
    if (!c[CFG_ADVALL]) begin
      a = {!lo && !hf, !lo, !hf, 1'b1};
      if (lo && hf) a = 4'h1;
    end
    // Single mode keeps only the highest ability in a: the highest the pins allow, or 100F when CFG_ADVALL is set.
    if (c[CFG_ADVSINGLE]) a = a[3] ? 4'h8 : (a[2] ? 4'h4 : (a[1] ? 4'h2 : 4'h1));
    pinAbil = a;
  endfunction

  // Register file and negotiation state.
  logic [15:0] ctrl_r, ctrl_nxt, adv_r, adv_nxt, part_r, part_nxt, cfg_r, cfg_nxt;
  logic done_r, done_nxt, rfault_r, rfault_nxt;
  pac_state_t state_r, state_nxt;
  logic [$clog2(NEG_CYCLES+1)-1:0] cnt_r, cnt_nxt;
  logic [15:0] rdWord;
  logic apbWr, apbAcc, init_r;
  logic [3:0] idx;
  assign apbAcc = psel && penable && !pready;
  // Writes land at the completing edge, where pready stands high.
  assign apbWr = psel && penable && pready && pwrite;
  assign idx = paddr[5:2];
  logic [15:0] statWord;
  assign statWord = STAT_FIXED | (16'(done_r) << STAT_ANDONE) | (16'(rfault_r) << STAT_RFAULT)
                  | (16'(partSync_r[0]) << STAT_LINK);

  always_comb begin
    ctrl_nxt = ctrl_r;
    adv_nxt = adv_r;
    part_nxt = part_r;
    cfg_nxt = cfg_r;
    done_nxt = done_r;
    rfault_nxt = rfault_r;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    // Restart self-clears first, so a software write in the same cycle wins.
    if (ctrl_r[CTRL_RESTART]) ctrl_nxt[CTRL_RESTART] = 1'b0;
    // Pins set defaults into advertisement and control.
    if (init_r) begin
      adv_nxt = ADV_SELECTOR;
      {adv_nxt[ADV_100F], adv_nxt[ADV_100H], adv_nxt[ADV_10F], adv_nxt[ADV_10H]} =
        pinAbil(cfg_r, lowHint, halfHint);
      ctrl_nxt = 16'h0000;
      ctrl_nxt[CTRL_ANEN] = !negDis;
      ctrl_nxt[CTRL_SPEED] = !lowHint;
      ctrl_nxt[CTRL_DUPLEX] = !halfHint;
    end
    if (apbWr) begin
      case (idx)
        REG_IDX_CTRL: ctrl_nxt = pwdata[15:0];
        REG_IDX_ADV: adv_nxt = pwdata[15:0];
        REG_IDX_CFG: cfg_nxt = pwdata[15:0];
        default: ;
      endcase
    end
    case (state_r)
      PAC_IDLE: begin
        if (ctrl_r[CTRL_ANEN]) begin
          state_nxt = PAC_SEND;
          done_nxt = 1'b0;
          cnt_nxt = '0;
        end else if (!init_r) begin
          state_nxt = PAC_FORCE;
        end
      end
      PAC_SEND: begin
        // Saturate so a late partner never wraps the wait back to zero.
        if (cnt_r < ($bits(cnt_r))'(NEG_CYCLES - 1)) cnt_nxt = cnt_r + 1'b1;
        if (partSync_r[1] && cnt_r >= ($bits(cnt_r))'(NEG_CYCLES - 1)) begin
          part_nxt = partnerWord;
          rfault_nxt = partnerWord[ADV_RFAULT];
          done_nxt = 1'b1;
          state_nxt = PAC_DONE;
        end
      end
      PAC_DONE: begin
        if (!ctrl_r[CTRL_ANEN] || ctrl_r[CTRL_RESTART] || !partSync_r[0]) begin
          state_nxt = PAC_IDLE;
          done_nxt = 1'b0;
        end
      end
      PAC_FORCE: begin
        if (ctrl_r[CTRL_ANEN]) state_nxt = PAC_IDLE;
      end
      default: state_nxt = PAC_IDLE;
    endcase
  end

  // Register state.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_r <= 16'h0000;
      adv_r <= 16'h0000;
      part_r <= 16'h0000;
      cfg_r <= CFG_RESET;
      done_r <= 1'b0;
      rfault_r <= 1'b0;
      state_r <= PAC_IDLE;
      cnt_r <= '0;
      init_r <= 1'b0;
    end else if (clkEn) begin
      ctrl_r <= ctrl_nxt;
      adv_r <= adv_nxt;
      part_r <= part_nxt;
      cfg_r <= cfg_nxt;
      done_r <= done_nxt;
      rfault_r <= rfault_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      init_r <= capture;
    end
  end

  // Read mux.
  always_comb begin
    case (idx)
      REG_IDX_CTRL: rdWord = ctrl_r;
      REG_IDX_STAT: rdWord = statWord;
      REG_IDX_ADV: rdWord = adv_r;
      REG_IDX_PART: rdWord = part_r;
      REG_IDX_CFG: rdWord = cfg_r;
      REG_IDX_PORTSEL: rdWord = {5'h00, strap_r};
      default: rdWord = 16'h0000;
    endcase
  end

  // Output registers, including APB answer and pin drive.
  logic [1:0] modeNxt;
  always_comb begin
    if (ctrl_r[CTRL_ANEN]) modeNxt = bestMode(abil(adv_r) & abil(part_r));
    else modeNxt = {ctrl_r[CTRL_SPEED], ctrl_r[CTRL_DUPLEX]};
  end
  logic pinsLive;
  assign pinsLive = rcSync_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      romSelectOut <= 1'b0;
      romSelectOe <= 1'b0;
      serialClockOut <= 1'b0;
      serialClockOe <= 1'b0;
      serialDataOut <= 1'b0;
      serialDataOe <= 1'b0;
      engDataIn <= 1'b0;
      serialPathSelect <= 1'b0;
      link_pulse_burst <= 16'h0000;
      burstValid <= 1'b0;
      resolvedMode <= 2'h0;
      flowCtlEnable <= 2'h0;
      crossoverMdi <= 1'b0;
      intOut <= 1'b0;
      intOe <= 1'b0;
    end else if (clkEn) begin
      pready <= apbAcc;
      pslverr <= apbAcc && (idx > REG_IDX_PORTSEL || (idx > REG_IDX_PART && idx < REG_IDX_CFG)
                 || idx == 4'h2 || idx == 4'h3);
      prdata <= apbAcc ? {16'h0000, rdWord} : 32'h00000000;
      serialPathSelect <= strap_r[10];
      // EEPROM path drives select, clock and data; management path drives clock, drives data when engDataOe is set, and reads data.
      romSelectOut <= engSelect;
      romSelectOe <= pinsLive && strap_r[10];
      serialClockOut <= engClock;
      serialClockOe <= pinsLive;
      serialDataOut <= engData;
      serialDataOe <= pinsLive && (strap_r[10] || engDataOe);
      engDataIn <= strap_r[10] ? serSync_r[0] : serSync_r[1];
      link_pulse_burst <= adv_r;
      burstValid <= state_r == PAC_SEND;
      resolvedMode <= modeNxt;
      flowCtlEnable <= ~{strap_r[3], strap_r[2]};
      crossoverMdi <= xoEn ? 1'b0 : xoSel;
      // Open drain: pull low on an event when CFG_INTPOL is clear, and with no event when it is set.
      intOut <= 1'b0;
      intOe <= cfg_r[CFG_INTPOL] ? !intEvent : intEvent;
    end
  end

  // Checks.
  property p_ctrl_default;
    @(posedge clock) disable iff (rst) (init_r && clkEn && !apbWr) |=>
      ctrl_r[CTRL_ANEN] == !negDis;
  endproperty
  a_ctrl_default: assert property (p_ctrl_default) else $error("control default wrong");
  property p_int_pol;
    @(posedge clock) disable iff (rst) clkEn |=>
      intOe == ($past(cfg_r[CFG_INTPOL]) ? !$past(intEvent) : $past(intEvent));
  endproperty
  a_int_pol: assert property (p_int_pol) else $error("interrupt polarity wrong");
  property p_tristate;
    @(posedge clock) disable iff (rst) (clkEn && !rcSync_r) |=> !serialClockOe && !romSelectOe;
  endproperty
  a_tristate: assert property (p_tristate) else $error("pins driven in reset");
  property p_wait_enable;
    @(posedge clock) disable iff (rst) (state_r == PAC_FORCE && !ctrl_r[CTRL_ANEN]) |=>
      state_r != PAC_SEND;
  endproperty
  a_wait_enable: assert property (p_wait_enable) else $error("negotiation began early");
  property p_done_store;
    @(posedge clock) disable iff (rst) ($rose(done_r)) |-> part_r == $past(partnerWord);
  endproperty
  a_done_store: assert property (p_done_store) else $error("partner not stored");
  property p_status_fixed;
    @(posedge clock) disable iff (rst) (statWord & STAT_FIXED) == STAT_FIXED;
  endproperty
  a_status_fixed: assert property (p_status_fixed) else $error("fixed status bits lost");
  property p_done_status;
    @(posedge clock) disable iff (rst) statWord[STAT_ANDONE] == (state_r == PAC_DONE);
  endproperty
  a_done_status: assert property (p_done_status) else $error("done flag mismatch");
  property p_xover;
    @(posedge clock) disable iff (rst) (clkEn && xoEn) |=> !crossoverMdi;
  endproperty
  a_xover: assert property (p_xover) else $error("crossover select not ignored");
  property p_forced;
    @(posedge clock) disable iff (rst) (clkEn && !ctrl_r[CTRL_ANEN]) |=>
      resolvedMode == {$past(ctrl_r[CTRL_SPEED]), $past(ctrl_r[CTRL_DUPLEX])};
  endproperty
  a_forced: assert property (p_forced) else $error("forced mode wrong");
  c_done: cover property (@(posedge clock) disable iff (rst) $rose(done_r));
  c_force: cover property (@(posedge clock) disable iff (rst) state_r == PAC_FORCE);
  c_write: cover property (@(posedge clock) disable iff (rst) apbWr && idx == REG_IDX_ADV);
endmodule // pac_autoneg
`default_nettype wire

// File: verification/pac_link_partner.sv
`timescale 1ns/100ps
`default_nettype none
module pac_link_partner (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Burst from the device and the word this partner offers.
  input wire logic burstValid,
  input wire logic [15:0] offerWord,
  input wire logic [7:0] answerDelay,
  // Answer toward the device.
  output logic partnerValid,
  output logic [15:0] partnerWord,
  output logic linkUp
);
  int cnt;
  // Answers a burst after a chosen delay; outside an answer the word keeps changing.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      partnerValid <= 1'b0;
      partnerWord <= 16'h5A5A;
      linkUp <= 1'b0;
    end else if (!burstValid) begin
      cnt <= 0;
      partnerValid <= 1'b0;
      partnerWord <= ~partnerWord;
    end else if (cnt < int'(answerDelay)) begin
      cnt <= cnt + 1;
      partnerWord <= ~partnerWord;
    end else begin
      partnerValid <= 1'b1;
      partnerWord <= offerWord;
      linkUp <= 1'b1;
    end
  end
endmodule // pac_link_partner
`default_nettype wire

// File: verification/pac_autoneg_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pac_autoneg_tb;
  import pac_pkg::*;
  logic clock, rst, clkEn, power_on_rc_input, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, answerDelay;
  logic [31:0] pwdata, prdata;
  logic [1:0] portNegDisable, portHalfDuplexHint, portLowSpeedHint, portFlowCtlOff;
  logic [1:0] flowCtlEnable, resolvedMode;
  logic auto_crossover_enable, port0_crossover_select, romSelectIn, romSelectOut, romSelectOe;
  logic serialClockIn, serialClockOut, serialClockOe, serialDataIn, serialDataOut, serialDataOe;
  logic rom_serial_in, engClock, engData, engDataOe, engSelect, engDataIn, serialPathSelect;
  logic partnerValid, linkUp, burstValid, crossoverMdi, intEvent, intOut, intOe, selStrap;
  logic busErr;
  logic [15:0] partnerWord, link_pulse_burst, offerWord, v, adv;
  int errCount, testsRun, seed, i, k;

  // Pin levels from every driver's enable; select falls back to selStrap, pull-ups on clock and data.
  assign romSelectIn = romSelectOe ? romSelectOut : selStrap;
  assign serialClockIn = serialClockOe ? serialClockOut : 1'b1;
  assign serialDataIn = serialDataOe ? serialDataOut : 1'b1;

  pac_autoneg pac_autoneg_i (.clock, .rst, .clkEn, .power_on_rc_input, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .portNegDisable,
    .portHalfDuplexHint, .portLowSpeedHint, .portFlowCtlOff, .auto_crossover_enable,
    .port0_crossover_select, .romSelectIn, .romSelectOut, .romSelectOe, .serialClockIn,
    .serialClockOut, .serialClockOe, .serialDataIn, .serialDataOut, .serialDataOe,
    .rom_serial_in, .engClock, .engData, .engDataOe, .engSelect, .engDataIn,
    .serialPathSelect, .partnerValid, .partnerWord, .linkUp, .link_pulse_burst, .burstValid,
    .resolvedMode, .flowCtlEnable, .crossoverMdi, .intEvent, .intOut, .intOe);

  pac_link_partner pac_link_partner_i (.clock, .rst, .burstValid, .offerWord, .answerDelay,
    .partnerValid, .partnerWord, .linkUp);

  // A 100 ns clock.
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmpReg(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %0t register got %h want %h", $time, got, exp);
    end
  endtask

  task automatic cmpPin(input logic [3:0] got, input logic [3:0] exp);
    testsRun++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %0t pin got %h want %h", $time, got, exp);
    end
  endtask

  // One APB transfer; entered just after a rising edge, holds the request until pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [15:0] r, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      errCount++;
      $display("[ERR] %0t bus answer missing", $time);
      summarize();
    end
    r = prdata[15:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] r);
    logic e;
    apb(1'b0, a, 16'h0000, r, e);
  endtask

  // Model of the resolved mode: highest common technology.
  function automatic int modeOf(input int c);
    if (c & 256) return 3;
    if (c & 128) return 2;
    if (c & 64) return 1;
    return 0;
  endfunction

  // Reset, strap capture on the power-on input, then a strap change that must be ignored.
  task automatic boot(input logic sel, input logic [1:0] fc);
    rst <= 1'b1;
    power_on_rc_input <= 1'b0;
    selStrap <= sel;
    portFlowCtlOff <= fc;
    port0_crossover_select <= sel;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    cmpPin({1'b0, romSelectOe, serialClockOe, serialDataOe}, 4'h0);
    power_on_rc_input <= 1'b1;
    repeat (8) @(posedge clock);
    portFlowCtlOff <= ~fc;
    port0_crossover_select <= ~sel;
    repeat (4) @(posedge clock);
    cmpPin({3'h0, serialPathSelect}, {3'h0, sel});
    cmpPin({2'h0, flowCtlEnable}, {2'h0, ~fc});
    cmpPin({3'h0, crossoverMdi}, {3'h0, sel});
  endtask

  // Hang guard.
  initial begin
    repeat (90000) @(posedge clock);
    errCount++;
    $display("[ERR] %0t run limit reached", $time);
    summarize();
  end

  initial begin
    seed = 32'h2f076f92;
    rst = 1'b1;
    clkEn = 1'b1;
    power_on_rc_input = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    portNegDisable = 2'b11;
    portHalfDuplexHint = 2'b11;
    portLowSpeedHint = 2'b11;
    portFlowCtlOff = 2'b00;
    auto_crossover_enable = 1'b0;
    port0_crossover_select = 1'b0;
    selStrap = 1'b0;
    rom_serial_in = 1'b1;
    engClock = 1'b0;
    engData = 1'b0;
    engDataOe = 1'b0;
    engSelect = 1'b0;
    intEvent = 1'b0;
    offerWord = 16'h0000;
    answerDelay = 8'h00;
    errCount = 0;
    testsRun = 0;
    boot(1'b1, 2'b01);
    boot(1'b0, 2'b10);
    // Engine drives the shared pins, then releases data to the pull-up.
    engClock <= 1'b1;
    engDataOe <= 1'b1;
    engSelect <= 1'b1;
    repeat (6) @(posedge clock);
    cmpPin({serialClockOut, serialDataOut, serialDataOe, engDataIn}, 4'hA);
    engDataOe <= 1'b0;
    repeat (6) @(posedge clock);
    cmpPin({2'h0, serialDataOe, engDataIn}, 4'h1);
    rd(8'h04, v);
    cmpReg(v & 16'hF82D, STAT_FIXED);
    apb(1'b0, 8'h3C, 16'h0000, v, busErr);
    cmpPin({3'h0, busErr}, 4'h1);
    rd(8'h10, v);
    cmpReg(v & 16'h01E0, 16'h01E0);
    cmpPin({3'h0, burstValid}, 4'h0);
    for (k = 0; k < 4; k++) begin
      adv = ADV_SELECTOR | 16'h0020 | (16'($random(seed)) & 16'h01C0);
      offerWord <= 16'h0020 | (16'($random(seed)) & 16'h21C0);
      answerDelay <= 8'(k * 60);
      wr(8'h10, adv);
      wr(8'h00, 16'h1200);
      repeat (3) @(posedge clock);
      cmpPin({3'h0, burstValid}, 4'h1);
      cmpReg(link_pulse_burst, adv);
      for (i = 0; i < 40; i++) begin
        rd(8'h04, v);
        if (v[STAT_ANDONE] === 1'b1) break;
        repeat (50) @(posedge clock);
      end
      cmpReg(v & 16'h0034, (16'(offerWord[13]) << STAT_RFAULT) | 16'h0024);
      rd(8'h14, v);
      cmpReg(v, offerWord);
      cmpPin({2'h0, resolvedMode}, 4'(modeOf(int'(adv & offerWord))));
    end
    for (k = 0; k < 4; k++) begin
      wr(8'h00, (16'(k / 2) << CTRL_SPEED) | (16'(k % 2) << CTRL_DUPLEX));
      repeat (4) @(posedge clock);
      cmpPin({2'h0, resolvedMode}, 4'(k));
    end
    for (k = 0; k < 4; k++) begin
      wr(8'h20, (16'(k / 2) << CFG_INTPOL) | CFG_RESET);
      intEvent <= k[0];
      repeat (4) @(posedge clock);
      cmpPin({2'h0, intOut, intOe}, {3'h0, k[0] ^ k[1]});
    end
    summarize();
  end
endmodule // pac_autoneg_tb
`default_nettype wire
